//--- rtl/bst_transceiver.sv
/*
  Bisync serial transceiver: Avalon-MM register slave, transmitter with sync fill,
  receiver with hunt and double-sync detection, modem control lines.
  Assumes modem bit clocks are far slower than clk_sys_in and arrive asynchronously.
*/
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module bst_transceiver
  import bst_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic tx_clk_in,
  input wire logic rx_clk_in,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic rxd_in,
  input wire logic sync_detect_in,
  output logic sync_detect_out,
  output logic sync_detect_oe_out,
  output logic txd_out,
  output logic rts_n_out,
  output logic dtr_n_out,
  output logic tx_ready_out,
  output logic rx_char_ready_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] char_len_f(input bst_mode_s m);
    char_len_f = BST_MIN_LEN + {2'b00, m.len_code};
  endfunction

  function automatic logic [3:0] frame_bits_f(input bst_mode_s m);
    frame_bits_f = char_len_f(m) + {3'b000, m.par_en};
  endfunction

  function automatic logic [7:0] len_mask_f(input bst_mode_s m);
    len_mask_f = 8'hff >> (4'h8 - char_len_f(m));
  endfunction

  function automatic logic [8:0] frame_f(input logic [7:0] d, input bst_mode_s m);
    logic [8:0] f;
    f = {1'b0, d & len_mask_f(m)};
    if (m.par_en) begin
      f[char_len_f(m)] = (^f[7:0]) ^ ~m.even_par;
    end
    frame_f = f;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Order: tx clock, rx clock, cts, dsr, rxd, sync pin.
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [2:0] prev_q;
  logic txc_s, rxc_s, cts_n_s, dsr_n_s, rxd_s, sdi_s;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 6'h3f;
      sync_q <= 6'h3f;
      prev_q <= 3'h7;
    end else if (ce_in) begin
      meta_q <= {tx_clk_in, rx_clk_in, cts_n_in, dsr_n_in, rxd_in, sync_detect_in};
      sync_q <= meta_q;
      prev_q <= {sync_q[5], sync_q[4], sync_q[0]};
    end
  end

  assign {txc_s, rxc_s, cts_n_s, dsr_n_s, rxd_s, sdi_s} = sync_q;

  logic tx_fall, rx_rise, sdi_rise;
  assign tx_fall = prev_q[2] & ~txc_s;
  assign rx_rise = ~prev_q[1] & rxc_s;
  assign sdi_rise = ~prev_q[0] & sdi_s;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // One wait cycle per access keeps read data registered and fixed latency.
  logic wait_q;
  logic [7:0] rdata_q;
  logic req, acc, wr_ev, rd_ev;
  logic [7:0] wd;

  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~wait_q;
  assign wr_ev = acc & avs_write_in & avs_byteenable_in[0];
  assign rd_ev = acc & avs_read_in;
  assign wd = avs_writedata_in[7:0];

  bst_mode_s wd_mode;
  bst_cmd_s wd_cmd;
  assign wd_mode = bst_mode_s'(wd);
  assign wd_cmd = bst_cmd_s'(wd);

  logic wr_data, wr_mode, wr_cmd, rd_data, rd_stat;
  assign wr_data = wr_ev & (avs_address_in == BST_ADDR_DATA);
  assign wr_mode = wr_ev & (avs_address_in == BST_ADDR_MODE);
  assign wr_cmd = wr_ev & (avs_address_in == BST_ADDR_CMD);
  assign rd_data = rd_ev & (avs_address_in == BST_ADDR_DATA);
  assign rd_stat = rd_ev & (avs_address_in == BST_ADDR_STAT);

  bst_mode_s mode_q;
  bst_cmd_s cmd_q;
  logic [7:0] sync1_q, sync2_q, thr_q, rbr_q;
  logic thr_full_q, txe_q, tx_rdy_q, rx_char_ready_q, pe_q, oe_q, syn_q;
  logic [7:0] status;

  // Bit positions come from the package so that software and logic share one map.
  always_comb begin
    status = 8'h00;
    status[BST_ST_TX_READY] = tx_rdy_q;
    status[BST_ST_RX_CHAR_READY] = rx_char_ready_q;
    status[BST_ST_TXE] = txe_q;
    status[BST_ST_PE] = pe_q;
    status[BST_ST_OE] = oe_q;
    status[BST_ST_SYNC_DETECT] = syn_q;
    status[BST_ST_DSR] = ~dsr_n_s;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_q <= 1'b1;
      rdata_q <= 8'h00;
    end else if (ce_in) begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        case (avs_address_in)
          BST_ADDR_DATA: rdata_q <= rbr_q;
          BST_ADDR_MODE: rdata_q <= mode_q;
          BST_ADDR_CMD: rdata_q <= cmd_q;
          BST_ADDR_STAT: rdata_q <= status;
          BST_ADDR_SYNC1: rdata_q <= sync1_q;
          BST_ADDR_SYNC2: rdata_q <= sync2_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = {24'h000000, rdata_q};

  // ----------------------------------------
  // Mode, command, sync and modem control
  // ----------------------------------------
  logic rts_n_q, dtr_n_q, sdo_oe_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q <= BST_MODE_RST;
      cmd_q <= BST_CMD_RST;
      sync1_q <= BST_SYNC_RST;
      sync2_q <= BST_SYNC_RST;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      sdo_oe_q <= 1'b1;
    end else if (ce_in) begin
      if (wr_mode) begin
        mode_q <= wd;
        sdo_oe_q <= ~wd_mode.ext_sync;
      end
      if (wr_cmd) begin
        cmd_q <= wd;
        rts_n_q <= ~wd_cmd.rts;
        dtr_n_q <= ~wd_cmd.dtr;
      end
      if (wr_ev & (avs_address_in == BST_ADDR_SYNC1)) sync1_q <= wd;
      if (wr_ev & (avs_address_in == BST_ADDR_SYNC2)) sync2_q <= wd;
    end
  end

  assign rts_n_out = rts_n_q;
  assign dtr_n_out = dtr_n_q;
  assign sync_detect_oe_out = sdo_oe_q;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic tx_on_q, fill_sel_q, txd_q;
  logic [7:0] tsh_q;
  logic [3:0] tbits_q;
  logic tx_en, load_thr, load_fill;
  logic [8:0] tx_word;

  assign tx_en = cmd_q.txen & ~cts_n_s;
  assign load_thr = tx_fall & (tbits_q == 4'h0) & thr_full_q & (tx_en | tx_on_q);
  assign load_fill = tx_fall & (tbits_q == 4'h0) & ~thr_full_q & tx_on_q & tx_en;
  assign tx_word = load_thr ? frame_f(thr_q, mode_q) :
                   frame_f((fill_sel_q & ~mode_q.single_sync) ? sync2_q : sync1_q, mode_q);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      txd_q <= 1'b1;
      tsh_q <= 8'h00;
      tbits_q <= 4'h0;
      tx_on_q <= 1'b0;
      fill_sel_q <= 1'b0;
    end else if (ce_in && tx_fall) begin
      if (tbits_q != 4'h0) begin
        txd_q <= tsh_q[0];
        tsh_q <= tsh_q >> 1;
        tbits_q <= tbits_q - 4'h1;
      end else if (load_thr | load_fill) begin
        txd_q <= tx_word[0];
        tsh_q <= tx_word[8:1];
        tbits_q <= frame_bits_f(mode_q) - 4'h1;
        tx_on_q <= 1'b1;
        fill_sel_q <= load_fill ? ~fill_sel_q : 1'b0;
      end else begin
        txd_q <= 1'b1;
        tx_on_q <= 1'b0;
        fill_sel_q <= 1'b0;
      end
    end
  end

  assign txd_out = txd_q;

  logic thr_full_d;
  assign thr_full_d = wr_data | (thr_full_q & ~load_thr);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
      tx_rdy_q <= 1'b0;
      txe_q <= 1'b1;
    end else if (ce_in) begin
      if (wr_data) thr_q <= wd;
      thr_full_q <= thr_full_d;
      tx_rdy_q <= (wr_cmd ? wd_cmd.txen : cmd_q.txen) & ~thr_full_d;
      if (load_fill) begin
        txe_q <= 1'b1;
      end else if (wr_data) begin
        txe_q <= 1'b0;
      end
    end
  end

  assign tx_ready_out = tx_rdy_q;

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  bst_rx_e rx_st_q;
  logic [8:0] rsr_q;
  logic [3:0] rcnt_q;
  logic [8:0] rsr_n, rx_frame, hunt_win;
  logic last_bit, sync1_hit, sync2_hit, perr;
  logic char_ev, syn_ev;

  assign rsr_n = {rxd_s, rsr_q[8:1]};
  assign rx_frame = rsr_n >> (4'h9 - frame_bits_f(mode_q));
  assign hunt_win = rsr_n >> (4'h9 - char_len_f(mode_q));
  assign last_bit = (rcnt_q == frame_bits_f(mode_q) - 4'h1);
  assign sync1_hit = (hunt_win[7:0] == (sync1_q & len_mask_f(mode_q)));
  assign sync2_hit = ((rx_frame[7:0] & len_mask_f(mode_q)) == (sync2_q & len_mask_f(mode_q)));
  assign perr = mode_q.par_en & ((^rx_frame) ^ ~mode_q.even_par);
  assign char_ev = rx_rise & (rx_st_q == RX_DATA) & last_bit;
  assign syn_ev = (rx_rise & ~mode_q.ext_sync & (rx_st_q == RX_SYNC2) & last_bit & sync2_hit) |
                  (mode_q.ext_sync & sdi_rise & (rx_st_q == RX_HUNT));

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsr_q <= 9'h000;
    end else if (ce_in && rx_rise) begin
      rsr_q <= rsr_n;
    end
  end

  // Without parity the first sync has no tail bit, so a match moves straight on.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_st_q <= RX_HUNT;
      rcnt_q <= 4'h0;
    end else if (ce_in) begin
      if (wr_cmd & wd_cmd.hunt) begin
        rx_st_q <= RX_HUNT;
        rcnt_q <= 4'h0;
      end else if (syn_ev & mode_q.ext_sync) begin
        rx_st_q <= RX_DATA;
        rcnt_q <= 4'h0;
      end else if (rx_rise) begin
        case (rx_st_q)
          RX_HUNT: begin
            if (~mode_q.ext_sync & sync1_hit) begin
              rcnt_q <= mode_q.par_en ? char_len_f(mode_q) : 4'h0;
              if (mode_q.par_en) begin
                rx_st_q <= RX_TAIL;
              end else begin
                rx_st_q <= mode_q.single_sync ? RX_DATA : RX_SYNC2;
              end
            end
          end
          RX_TAIL: begin
            rcnt_q <= 4'h0;
            rx_st_q <= mode_q.single_sync ? RX_DATA : RX_SYNC2;
          end
          RX_SYNC2: begin
            if (last_bit) begin
              rcnt_q <= 4'h0;
              rx_st_q <= sync2_hit ? RX_DATA : RX_HUNT;
            end else begin
              rcnt_q <= rcnt_q + 4'h1;
            end
          end
          RX_DATA: begin
            rcnt_q <= last_bit ? 4'h0 : rcnt_q + 4'h1;
          end
          default: begin
            rx_st_q <= RX_HUNT;
            rcnt_q <= 4'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Receive flags
  // ----------------------------------------
  // Hardware events win over a clear arriving in the same cycle.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rbr_q <= 8'h00;
      rx_char_ready_q <= 1'b0;
      pe_q <= 1'b0;
      oe_q <= 1'b0;
      syn_q <= 1'b0;
    end else if (ce_in) begin
      if (char_ev) rbr_q <= rx_frame[7:0] & len_mask_f(mode_q);
      if (!cmd_q.rxen) begin
        rx_char_ready_q <= 1'b0;
      end else if (char_ev) begin
        rx_char_ready_q <= 1'b1;
      end else if (rd_data) begin
        rx_char_ready_q <= 1'b0;
      end
      if (char_ev & perr) begin
        pe_q <= 1'b1;
      end else if (wr_cmd & wd_cmd.err_rst) begin
        pe_q <= 1'b0;
      end
      if (char_ev & rx_char_ready_q & ~rd_data) begin
        oe_q <= 1'b1;
      end else if (wr_cmd & wd_cmd.err_rst) begin
        oe_q <= 1'b0;
      end
      if (syn_ev) begin
        syn_q <= 1'b1;
      end else if (rd_stat) begin
        syn_q <= 1'b0;
      end
    end
  end

  // The pin drive is registered from the next flag and direction values, so it
  // follows the status flag in the same cycle instead of one cycle late.
  logic sd_pin_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sd_pin_q <= 1'b0;
    end else if (ce_in) begin
      sd_pin_q <= (syn_ev | (syn_q & ~rd_stat)) &
                  (wr_mode ? ~wd_mode.ext_sync : sdo_oe_q);
    end
  end

  assign rx_char_ready_out = rx_char_ready_q;
  assign sync_detect_out = sd_pin_q;

endmodule
`default_nettype wire

//--- rtl/bst_pkg.sv
/*
  Constants, register map and carrier types of the bisync serial transceiver.
  Assumes a single system clock; the modem bit clocks are sampled as plain inputs.
*/
package bst_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] BST_ADDR_DATA = 5'h00;
  localparam logic [4:0] BST_ADDR_MODE = 5'h04;
  localparam logic [4:0] BST_ADDR_CMD = 5'h08;
  localparam logic [4:0] BST_ADDR_STAT = 5'h0c;
  localparam logic [4:0] BST_ADDR_SYNC1 = 5'h10;
  localparam logic [4:0] BST_ADDR_SYNC2 = 5'h14;

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int BST_ST_TX_READY = 0;
  localparam int BST_ST_RX_CHAR_READY = 1;
  localparam int BST_ST_TXE = 2;
  localparam int BST_ST_PE = 3;
  localparam int BST_ST_OE = 4;
  localparam int BST_ST_SYNC_DETECT = 6;
  localparam int BST_ST_DSR = 7;

  // ----------------------------------------
  // Word layouts and reset values
  // ----------------------------------------
  typedef struct packed {
    logic single_sync;
    logic ext_sync;
    logic even_par;
    logic par_en;
    logic [1:0] len_code;
    logic [1:0] unused;
  } bst_mode_s;

  typedef struct packed {
    logic hunt;
    logic int_reset;
    logic rts;
    logic err_rst;
    logic brk;
    logic rxen;
    logic dtr;
    logic txen;
  } bst_cmd_s;

  localparam logic [7:0] BST_MODE_RST = 8'h0c;
  localparam logic [7:0] BST_CMD_RST = 8'h00;
  localparam logic [7:0] BST_SYNC_RST = 8'h00;
  localparam logic [3:0] BST_MIN_LEN = 4'h5;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_TAIL = 4'b0010,
    RX_SYNC2 = 4'b0100,
    RX_DATA = 4'b1000
  } bst_rx_e;

endpackage

//--- sim/bst_monitor.sv
/*
  Concurrent checks on the ports of the bisync serial transceiver.
  Assumes one system clock domain and bit clocks far slower than it.
*/
`timescale 1ns/1ns
`default_nettype none
module bst_monitor
  import bst_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic tx_clk_in,
  input wire logic rx_clk_in,
  input wire logic sync_detect_out,
  input wire logic sync_detect_oe_out,
  input wire logic txd_out,
  input wire logic rts_n_out,
  input wire logic dtr_n_out,
  input wire logic tx_ready_out
);
  // ----------------------------------------
  // Bit clock edge age counters
  // ----------------------------------------
  // Pin edges are seen one clock late here, so windows allow a cycle of slack.
  logic tx_prev_q, rx_prev_q;
  logic [3:0] tx_age_q, rx_age_q;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_prev_q <= 1'h1;
      rx_prev_q <= 1'h1;
      tx_age_q <= 4'hf;
      rx_age_q <= 4'hf;
    end else begin
      tx_prev_q <= tx_clk_in;
      rx_prev_q <= rx_clk_in;
      tx_age_q <= (tx_prev_q && !tx_clk_in) ? 4'h0 : tx_age_q + {3'h0, tx_age_q != 4'hf};
      rx_age_q <= (!rx_prev_q && rx_clk_in) ? 4'h0 : rx_age_q + {3'h0, rx_age_q != 4'hf};
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_wr(logic [4:0] a);
    avs_write_in && !avs_waitrequest_out && avs_address_in == a && avs_byteenable_in[0];
  endsequence
  sequence s_stat_rd;
    avs_read_in && !avs_waitrequest_out && avs_address_in == BST_ADDR_STAT;
  endsequence

  chk_cmd_lines: assert property (s_wr(BST_ADDR_CMD) |=>
    dtr_n_out == !$past(avs_writedata_in[1]) && rts_n_out == !$past(avs_writedata_in[5]))
    else $error("modem control lines do not follow command");
  chk_tx_ready_clear: assert property (s_wr(BST_ADDR_DATA) |=> !tx_ready_out)
    else $error("tx_ready not cleared by data write");
  chk_tx_ready_mask: assert property (s_wr(BST_ADDR_CMD) ##0 !avs_writedata_in[0]
    |=> !tx_ready_out [*3]) else $error("tx_ready not masked");
  chk_pin_dir: assert property (s_wr(BST_ADDR_MODE) |=>
    sync_detect_oe_out == !$past(avs_writedata_in[6])) else $error("sync pin direction wrong");
  chk_sd_clear: assert property (s_stat_rd |=> !sync_detect_out)
    else $error("sync pin not cleared by status read");
  chk_txd_timing: assert property ($changed(txd_out) |-> tx_age_q inside {[1:6]})
    else $error("serial out changed away from a falling bit clock edge");
  chk_sd_timing: assert property ($rose(sync_detect_out) |->
    sync_detect_oe_out && rx_age_q inside {[1:7]}) else $error("sync pin rose off mid bit");
  chk_reset_idle: assert property ($rose(arst_n_in) |-> txd_out && sync_detect_oe_out
    && !sync_detect_out && !tx_ready_out) else $error("outputs not idle after reset");
endmodule
`default_nettype wire

//--- sim/bst_modem.sv
/*
  Behavioural modem: free running bit clocks, serial source and sink.
  Assumes the bench queues receive frames with send and reads hist.
*/
`timescale 1ns/1ns
`default_nettype none
module bst_modem (
  output logic tx_clk_out,
  output logic rx_clk_out,
  output logic rxd_out,
  input wire logic txd_in
);
  // Synchronous links keep the bit clocks running, so they never stand still.
  logic q[$];
  logic [31:0] hist = 32'hffffffff;
  initial begin
    tx_clk_out = 1'h1;
    forever #400 tx_clk_out = ~tx_clk_out;
  end
  initial begin
    rx_clk_out = 1'h1;
    #137;
    forever #400 rx_clk_out = ~rx_clk_out;
  end
  initial rxd_out = 1'h0;
  // Idle line toggles so that no stale level can pose as data.
  always @(negedge rx_clk_out) begin
    if (q.size() > 0) rxd_out <= q.pop_front();
    else rxd_out <= ~rxd_out;
  end
  // Sampled at the end of each bit, just before the next falling edge.
  always @(negedge tx_clk_out) hist <= {txd_in, hist[31:1]};
  task automatic send(input logic [8:0] f);
    for (int i = 0; i < 9; i++) q.push_back(f[i]);
  endtask
endmodule
`default_nettype wire

//--- sim/bst_transceiver_bench.sv
/*
  Self-checking bench for the transceiver: Avalon-MM tasks and modem model.
  Assumes 10 MHz system clock and 800 ns modem bit clocks.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module bst_transceiver_bench
  import bst_pkg::*;
;
  logic clk_sys_in, arst_n_in, ce_in, avs_read_in, avs_write_in, cts_n_in, dsr_n_in;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  wire logic [31:0] avs_readdata_out;
  wire logic avs_waitrequest_out, tx_clk_in, rx_clk_in, rxd_in, sync_detect_in;
  wire logic sync_detect_out, sync_detect_oe_out, txd_out, rts_n_out, dtr_n_out;
  wire logic tx_ready_out, rx_char_ready_out;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] rdat;
  logic found;
  // The sync pin has a pull-down when nobody drives it.
  assign sync_detect_in = sync_detect_oe_out ? sync_detect_out : 1'h0;
  bst_transceiver dut (.clk_sys_in, .arst_n_in, .ce_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .tx_clk_in, .rx_clk_in, .cts_n_in, .dsr_n_in, .rxd_in,
    .sync_detect_in, .sync_detect_out, .sync_detect_oe_out, .txd_out, .rts_n_out,
    .dtr_n_out, .tx_ready_out, .rx_char_ready_out);
  bst_modem m (.tx_clk_out(tx_clk_in), .rx_clk_out(rx_clk_in), .rxd_out(rxd_in),
    .txd_in(txd_out));

  // ----------------------------------------
  // Bus and link tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_write_in <= 1'h1;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'h0);
    avs_write_in <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_read_in <= 1'h1;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'h0);
    d = avs_readdata_out[7:0];
    avs_read_in <= 1'h0;
  endtask
  task automatic wait_tx(input int k);
    repeat (k) @(negedge tx_clk_in);
    #1;
  endtask
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'h0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    arst_n_in = 1'h0;
    ce_in = 1'h1;
    avs_read_in = 1'h0;
    avs_write_in = 1'h0;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'h1;
    cts_n_in = 1'h1;
    dsr_n_in = 1'h1;
    repeat (16) @(posedge clk_sys_in);
    arst_n_in <= 1'h1;
    @(negedge clk_sys_in);
    `CHK("txd", txd_out, 1'h1)
    `CHK("dtr_rts", {dtr_n_out, rts_n_out}, 2'h3)
    `CHK("sd_pin", {sync_detect_oe_out, sync_detect_out}, 2'h2)
    rd(BST_ADDR_STAT, rdat);
    `CHK("status", rdat, 8'h04)
    rd(5'h18, rdat);
    `CHK("unmapped", rdat, 8'h00)
    $display("test reset done");
    wr(BST_ADDR_CMD, 8'h22);
    dsr_n_in <= 1'h0;
    repeat (6) @(negedge clk_sys_in);
    `CHK("dtr_rts_on", {dtr_n_out, rts_n_out}, 2'h0)
    rd(BST_ADDR_STAT, rdat);
    `CHK("dsr", rdat[BST_ST_DSR], 1'h1)
    $display("test modem lines done");
    wr(BST_ADDR_MODE, 8'h3c);
    wr(BST_ADDR_SYNC1, 8'h32);
    wr(BST_ADDR_SYNC2, 8'h32);
    wr(BST_ADDR_DATA, 8'h32);
    wr(BST_ADDR_CMD, 8'ha3);
    wait_tx(20);
    `CHK("hold_mark", m.hist, 32'hffffffff)
    @(posedge clk_sys_in);
    cts_n_in <= 1'h0;
    wait_tx(40);
    found = 1'h0;
    for (int k = 0; k < 15; k++) if (m.hist[k+:18] == {1'h1, 8'h32, 1'h1, 8'h32}) found = 1'h1;
    `CHK("fill", found, 1'h1)
    `CHK("tx_ready", tx_ready_out, 1'h1)
    rd(BST_ADDR_STAT, rdat);
    `CHK("txe_fill", rdat[BST_ST_TXE], 1'h1)
    wr(BST_ADDR_DATA, 8'h5a);
    @(negedge clk_sys_in);
    `CHK("tx_ready_wr", tx_ready_out, 1'h0)
    rd(BST_ADDR_STAT, rdat);
    `CHK("txe_wr", rdat[BST_ST_TXE], 1'h0)
    wr(BST_ADDR_CMD, 8'h22);
    found = 1'h0;
    for (n = 0; n < 30; n++) begin
      wait_tx(1);
      if (m.hist[31:23] == {1'h0, 8'h5a}) found = 1'h1;
    end
    `CHK("drain", found, 1'h1)
    wait_tx(40);
    `CHK("mark_off", m.hist, 32'hffffffff)
    `CHK("tx_ready_off", tx_ready_out, 1'h0)
    $display("test transmit done");
    wr(BST_ADDR_CMD, 8'ha6);
    m.send({^8'h32, 8'h32});
    m.send({^8'h32, 8'h32});
    m.send({^8'h81, 8'h81});
    m.send({~^8'h7e, 8'h7e});
    m.send({^8'h11, 8'h11});
    m.send({^8'h22, 8'h22});
    for (n = 0; n < 3000 && sync_detect_out !== 1'h1; n++) @(posedge clk_sys_in);
    `CHK("sd_pin_hi", sync_detect_out, 1'h1)
    rd(BST_ADDR_STAT, rdat);
    `CHK("sd_stat", rdat[BST_ST_SYNC_DETECT], 1'h1)
    @(negedge clk_sys_in);
    `CHK("sd_pin_lo", sync_detect_out, 1'h0)
    for (n = 0; n < 1000 && rx_char_ready_out !== 1'h1; n++) @(posedge clk_sys_in);
    rd(BST_ADDR_DATA, rdat);
    `CHK("rx_first", rdat, 8'h81)
    rd(BST_ADDR_STAT, rdat);
    `CHK("sd_auto", rdat[BST_ST_SYNC_DETECT], 1'h0)
    @(negedge clk_sys_in);
    for (n = 0; n < 1000 && rx_char_ready_out !== 1'h1; n++) @(posedge clk_sys_in);
    rd(BST_ADDR_STAT, rdat);
    `CHK("parity", rdat[BST_ST_PE], 1'h1)
    rd(BST_ADDR_DATA, rdat);
    while (m.q.size() > 0) @(posedge clk_sys_in);
    repeat (2) @(posedge rx_clk_in);
    repeat (8) @(posedge clk_sys_in);
    rd(BST_ADDR_STAT, rdat);
    `CHK("overrun", rdat[BST_ST_OE], 1'h1)
    rd(BST_ADDR_DATA, rdat);
    `CHK("rx_last", rdat, 8'h22)
    wr(BST_ADDR_CMD, 8'h32);
    rd(BST_ADDR_STAT, rdat);
    `CHK("err_clr", rdat[4:3], 2'h0)
    // Idle toggles keep assembling characters, so a missing mask would show here.
    repeat (100) @(negedge clk_sys_in);
    `CHK("rx_char_ready_off", rx_char_ready_out, 1'h0)
    $display("test receive done");
    test_done();
  end
endmodule

bind bst_transceiver bst_monitor mon (.clk_sys_in, .arst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .tx_clk_in,
  .rx_clk_in, .sync_detect_out, .sync_detect_oe_out, .txd_out, .rts_n_out, .dtr_n_out,
  .tx_ready_out);
`default_nettype wire
